/* hw/pwm_glue_map.vh */
`ifndef PWM_GLUE_MAP_VH
`define PWM_GLUE_MAP_VH

// Register byte offsets on the APB slave.
`define OFS_CLOCK_ENABLE_CTRL_A   12'h000
`define OFS_CLOCK_ENABLE_CTRL_B   12'h004
`define OFS_SYNC_CONFIG           12'h008
`define OFS_GLUE_STATUS           12'h00C

// Control register A fields.
`define BIT_GLOBAL_TB_START       1
`define BIT_CLK_EN_INST1          8
`define BIT_CLK_EN_INST2          16
`define BIT_CLK_EN_INST3          24

// Control register B fields.
`define BIT_CLK_EN_INST4          0
`define BIT_CLK_EN_INST5          8
`define BIT_CLK_EN_INST6          16
`define BIT_CLK_EN_INST7          24

// Writable bits and reset values of the control registers.
`define MASK_CTRL_A               32'h0101_0102
`define MASK_CTRL_B               32'h0101_0101
`define RESET_CTRL_A              32'h0101_0100
`define RESET_CTRL_B              32'h0101_0101

// Sync configuration register fields.
`define BIT_SYNC_SRC_TIMER        0
`define LSB_SYNC_IN_USE           8
`define MASK_SYNC_CONFIG          32'h0000_7F01
`define RESET_SYNC_CONFIG         32'h0000_7F00

// Status register fields.
`define LSB_STAT_CLK_EN           0
`define BIT_STAT_SYS_RESET        8
`define BIT_STAT_EXT_SYNC_OUT     9
`define BIT_STAT_TB_START         10
`define LSB_STAT_SYNC_IN          16

// Sync output pulse stretch length in peripheral clock cycles.
`define SYNC_OUT_STRETCH_CYCLES   8

`endif

/* hw/sync_pulse_stretcher.v */
`timescale 1ns/1ps
`default_nettype none

`include "pwm_glue_map.vh"

module sync_pulse_stretcher
#(
    parameter integer STRETCH_CYCLES = `SYNC_OUT_STRETCH_CYCLES,
    parameter integer COUNT_WIDTH    = 4
)
(
    input  wire i_mclk,
    input  wire i_reset,
    input  wire i_clk_en,
    input  wire i_pulse,
    output reg  o_stretched
);

    localparam integer           RELOAD_INT = STRETCH_CYCLES - 1;
    localparam [COUNT_WIDTH-1:0] RELOAD     = RELOAD_INT[COUNT_WIDTH-1:0];

    reg [COUNT_WIDTH-1:0] remaining;

    // A pulse that arrives while stretching restarts the full length.
    always @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            remaining   <= {COUNT_WIDTH{1'b0}};
            o_stretched <= 1'b0;
        end
        else if (i_clk_en)
        begin
            if (i_pulse)
            begin
                remaining   <= RELOAD;
                o_stretched <= 1'b1;
            end
            else if (remaining != {COUNT_WIDTH{1'b0}})
            begin
                remaining   <= remaining - {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
                o_stretched <= 1'b1;
            end
            else
            begin
                o_stretched <= 1'b0;
            end
        end
    end

endmodule // sync_pulse_stretcher

`default_nettype wire

/* hw/pwm_clock_gate_sync_glue.v */
// Operation
// - Each of seven PWM instances gets its own independent clock enable.
// - Enables sit at A bits 8,16,24 and B bits 0,8,16,24.
// - While system reset is low, all enables are ignored and every instance clocks.
// - After system reset goes high, each instance follows its enable bit.
// - Every clock enable bit resets to one.
// - Every instance has one sync input and output, chained into one scheme.
// - The first instance takes its sync input from an external pin.
// - Each instance can be set to use or ignore its sync input.
// - The timer coprocessor loop sync can drive the first instance sync input.
// - Global time-base start at A bit 1 resets to zero and starts aligned.
// - First instance sync output is stretched to eight cycles onto the pin.
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

`include "pwm_glue_map.vh"

module pwm_clock_gate_sync_glue
#(
    parameter integer INSTANCES  = 7,
    parameter integer ADDR_WIDTH = 12
)
(
    input  wire                  i_mclk,
    input  wire                  i_reset,
    input  wire                  i_clk_en,
    input  wire                  i_psel,
    input  wire                  i_penable,
    input  wire                  i_pwrite,
    input  wire [ADDR_WIDTH-1:0] i_paddr,
    input  wire [31:0]           i_pwdata,
    input  wire [3:0]            i_pstrb,
    output reg  [31:0]           o_prdata,
    output reg                   o_pready,
    output reg                   o_pslverr,
    input  wire                  i_system_reset_n,
    input  wire                  i_ext_sync_pin,
    input  wire                  i_timer_coprocessor_loop_sync,
    input  wire [INSTANCES-1:0]  i_pwm_sync_out,
    output reg  [INSTANCES-1:0]  o_pwm_instance_clock_enable,
    output reg  [INSTANCES-1:0]  o_pwm_sync_in,
    output reg                   o_global_timebase_clock_start,
    output wire                  o_ext_sync_out_pin
);

    reg [31:0] pwm_clock_enable_ctrl_a;
    reg [31:0] pwm_clock_enable_ctrl_b;
    reg [31:0] sync_config;

    // Three-stage input synchronisers; stage one feeds stage two only.
    reg        sysrst_s1;
    reg        sysrst_s2;
    reg        sysrst_s3;
    reg        sysrst_n_filt;
    reg        pin_s1;
    reg        pin_s2;
    reg        pin_s3;
    reg        pin_filt;

    wire       bus_access;
    wire       bus_commit;
    wire       hit_ctrl_a;
    wire       hit_ctrl_b;
    wire       hit_config;
    wire       hit_status;
    wire       addr_hit;

    reg  [INSTANCES-1:0] enable_bits;
    reg  [INSTANCES-1:0] next_clock_enable;
    reg  [INSTANCES-1:0] next_sync_in;
    reg  [INSTANCES-1:0] sync_in_use;
    reg                  first_sync_source;
    reg  [31:0]          next_rdata;
    reg  [31:0]          status_word;
    integer              k;
    integer              j;

    // Merges a byte-strobed write into the old value, touching only writable bits.
    function [31:0] strobed_write;
        input [31:0] old_value;
        input [31:0] wdata;
        input [3:0]  strobe;
        input [31:0] writable;
        reg   [31:0] lane_mask;
        begin
            lane_mask     = {{8{strobe[3]}}, {8{strobe[2]}}, {8{strobe[1]}}, {8{strobe[0]}}};
            lane_mask     = lane_mask & writable;
            strobed_write = (old_value & ~lane_mask) | (wdata & lane_mask);
        end
    endfunction

    // A synchronised level only changes once the last two stages agree.
    function filtered_level;
        input previous;
        input stage2;
        input stage3;
        begin
            if (stage2 == stage3)
            begin
                filtered_level = stage3;
            end
            else
            begin
                filtered_level = previous;
            end
        end
    endfunction

    assign bus_access = i_psel & i_penable;
    assign bus_commit = bus_access & o_pready;

    assign hit_ctrl_a = (i_paddr == `OFS_CLOCK_ENABLE_CTRL_A);
    assign hit_ctrl_b = (i_paddr == `OFS_CLOCK_ENABLE_CTRL_B);
    assign hit_config = (i_paddr == `OFS_SYNC_CONFIG);
    assign hit_status = (i_paddr == `OFS_GLUE_STATUS);
    assign addr_hit   = hit_ctrl_a | hit_ctrl_b | hit_config | hit_status;

    always @*
    begin
        enable_bits[0] = pwm_clock_enable_ctrl_a[`BIT_CLK_EN_INST1];
        enable_bits[1] = pwm_clock_enable_ctrl_a[`BIT_CLK_EN_INST2];
        enable_bits[2] = pwm_clock_enable_ctrl_a[`BIT_CLK_EN_INST3];
        enable_bits[3] = pwm_clock_enable_ctrl_b[`BIT_CLK_EN_INST4];
        enable_bits[4] = pwm_clock_enable_ctrl_b[`BIT_CLK_EN_INST5];
        enable_bits[5] = pwm_clock_enable_ctrl_b[`BIT_CLK_EN_INST6];
        enable_bits[6] = pwm_clock_enable_ctrl_b[`BIT_CLK_EN_INST7];
    end

    always @*
    begin
        for (k = 0; k < INSTANCES; k = k + 1)
        begin
            next_clock_enable[k] = ~sysrst_n_filt | enable_bits[k];
        end
    end

    always @*
    begin
        sync_in_use = sync_config[`LSB_SYNC_IN_USE +: INSTANCES];
        if (sync_config[`BIT_SYNC_SRC_TIMER])
        begin
            first_sync_source = i_timer_coprocessor_loop_sync;
        end
        else
        begin
            first_sync_source = pin_filt;
        end
        next_sync_in[0] = sync_in_use[0] & first_sync_source;
        for (j = 1; j < INSTANCES; j = j + 1)
        begin
            next_sync_in[j] = sync_in_use[j] & i_pwm_sync_out[j-1];
        end
    end

    always @*
    begin
        status_word = 32'h0000_0000;
        status_word[`LSB_STAT_CLK_EN +: INSTANCES] = o_pwm_instance_clock_enable;
        status_word[`BIT_STAT_SYS_RESET]           = ~sysrst_n_filt;
        status_word[`BIT_STAT_EXT_SYNC_OUT]        = o_ext_sync_out_pin;
        status_word[`BIT_STAT_TB_START]            = o_global_timebase_clock_start;
        status_word[`LSB_STAT_SYNC_IN +: INSTANCES] = o_pwm_sync_in;
    end

    always @*
    begin
        if (hit_ctrl_a)
        begin
            next_rdata = pwm_clock_enable_ctrl_a;
        end
        else if (hit_ctrl_b)
        begin
            next_rdata = pwm_clock_enable_ctrl_b;
        end
        else if (hit_config)
        begin
            next_rdata = sync_config;
        end
        else if (hit_status)
        begin
            next_rdata = status_word;
        end
        else
        begin
            next_rdata = 32'h0000_0000;
        end
    end

    // The slave inserts one wait state so that every answer comes from a flop.
    always @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h0000_0000;
        end
        else if (i_clk_en)
        begin
            if (bus_access & ~o_pready)
            begin
                o_pready  <= 1'b1;
                o_pslverr <= ~addr_hit | (i_pwrite & hit_status);
                o_prdata  <= i_pwrite ? 32'h0000_0000 : next_rdata;
            end
            else
            begin
                o_pready  <= 1'b0;
                o_pslverr <= 1'b0;
                o_prdata  <= 32'h0000_0000;
            end
        end
    end

    always @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            pwm_clock_enable_ctrl_a <= `RESET_CTRL_A;
            pwm_clock_enable_ctrl_b <= `RESET_CTRL_B;
            sync_config             <= `RESET_SYNC_CONFIG;
        end
        else if (i_clk_en & bus_commit & i_pwrite)
        begin
            if (hit_ctrl_a)
            begin
                pwm_clock_enable_ctrl_a <= strobed_write(pwm_clock_enable_ctrl_a, i_pwdata, i_pstrb,
                                                         `MASK_CTRL_A);
            end
            else if (hit_ctrl_b)
            begin
                pwm_clock_enable_ctrl_b <= strobed_write(pwm_clock_enable_ctrl_b, i_pwdata, i_pstrb,
                                                         `MASK_CTRL_B);
            end
            else if (hit_config)
            begin
                sync_config <= strobed_write(sync_config, i_pwdata, i_pstrb, `MASK_SYNC_CONFIG);
            end
        end
    end

    // Reset state of the system reset synchroniser reads as reset asserted, so clocks run.
    always @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            sysrst_s1     <= 1'b0;
            sysrst_s2     <= 1'b0;
            sysrst_s3     <= 1'b0;
            sysrst_n_filt <= 1'b0;
            pin_s1        <= 1'b0;
            pin_s2        <= 1'b0;
            pin_s3        <= 1'b0;
            pin_filt      <= 1'b0;
        end
        else if (i_clk_en)
        begin
            sysrst_s1     <= i_system_reset_n;
            sysrst_s2     <= sysrst_s1;
            sysrst_s3     <= sysrst_s2;
            sysrst_n_filt <= filtered_level(sysrst_n_filt, sysrst_s2, sysrst_s3);
            pin_s1        <= i_ext_sync_pin;
            pin_s2        <= pin_s1;
            pin_s3        <= pin_s2;
            pin_filt      <= filtered_level(pin_filt, pin_s2, pin_s3);
        end
    end

    // One flop drives the start to all instances, so their time bases begin on the same edge.
    always @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            o_pwm_instance_clock_enable   <= {INSTANCES{1'b1}};
            o_pwm_sync_in                 <= {INSTANCES{1'b0}};
            o_global_timebase_clock_start <= 1'b0;
        end
        else if (i_clk_en)
        begin
            o_pwm_instance_clock_enable   <= next_clock_enable;
            o_pwm_sync_in                 <= next_sync_in;
            o_global_timebase_clock_start <= pwm_clock_enable_ctrl_a[`BIT_GLOBAL_TB_START];
        end
    end

    sync_pulse_stretcher
    #(
        .STRETCH_CYCLES (`SYNC_OUT_STRETCH_CYCLES),
        .COUNT_WIDTH    (4)
    )
    u_sync_stretch
    (
        .i_mclk      (i_mclk),
        .i_reset     (i_reset),
        .i_clk_en    (i_clk_en),
        .i_pulse     (i_pwm_sync_out[0]),
        .o_stretched (o_ext_sync_out_pin)
    );

endmodule // pwm_clock_gate_sync_glue

`default_nettype wire

/* sim/pwm_glue_properties.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pwm_glue_map.vh"
module pwm_glue_properties
(
    input wire logic        i_mclk,
    input wire logic        i_reset,
    input wire logic        i_clk_en,
    input wire logic [3:0]  i_pstrb,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic        i_system_reset_n,
    input wire logic [6:0]  i_pwm_sync_out,
    input wire logic [6:0]  o_pwm_instance_clock_enable,
    input wire logic [6:0]  o_pwm_sync_in,
    input wire logic        o_global_timebase_clock_start,
    input wire logic        o_ext_sync_out_pin
);
    wire logic commit = i_psel && i_penable && o_pready && i_pwrite;
    wire logic on_a   = commit && (i_paddr == `OFS_CLOCK_ENABLE_CTRL_A);
    wire logic set_tb = on_a && i_pstrb[0] && i_pwdata[1];
    wire logic clr_e1 = on_a && i_pstrb[1] && !i_pwdata[8];
    default clocking cb @(posedge i_mclk); endclocking
    // A low clock enable freezes the block, so no timing promise runs through it.
    default disable iff (i_reset || !i_clk_en);
    a_ready_one_wait: assert property ((i_psel && i_penable && !o_pready) |=> o_pready)
        else $error("pready missing after access");
    a_ready_pulse: assert property (o_pready |=> !o_pready)
        else $error("pready longer than one cycle");
    a_idle_rdata_zero: assert property (!o_pready |-> o_prdata == 32'h0)
        else $error("read data outside answer");
    a_err_with_ready: assert property (o_pslverr |-> o_pready)
        else $error("pslverr without pready");
    a_reset_forces_on: assert property (!i_system_reset_n [*8] |-> o_pwm_instance_clock_enable == 7'h7F)
        else $error("enables not forced during system reset");
    a_clear_gates_clock: assert property ((i_system_reset_n [*8] ##0 clr_e1) |=> ##1 !o_pwm_instance_clock_enable[0])
        else $error("cleared enable still passes clock");
    a_chain_source: assert property ((o_pwm_sync_in[6:1] & ~$past(i_pwm_sync_out[5:0])) == 6'h0)
        else $error("sync input without upstream pulse");
    a_stretch_hold: assert property (i_pwm_sync_out[0] |=> o_ext_sync_out_pin [*8])
        else $error("sync out pin shorter than eight");
    a_stretch_end: assert property (!i_pwm_sync_out[0] [*8] |=> !o_ext_sync_out_pin)
        else $error("sync out pin longer than eight");
    a_start_cause: assert property ($rose(o_global_timebase_clock_start) |-> $past(set_tb, 2))
        else $error("time base started without write");
endmodule // pwm_glue_properties
bind pwm_clock_gate_sync_glue pwm_glue_properties u_props
(
    .i_mclk(i_mclk), .i_reset(i_reset), .i_clk_en(i_clk_en), .i_pstrb(i_pstrb),
    .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_system_reset_n(i_system_reset_n),
    .i_pwm_sync_out(i_pwm_sync_out), .o_pwm_instance_clock_enable(o_pwm_instance_clock_enable),
    .o_pwm_sync_in(o_pwm_sync_in), .o_global_timebase_clock_start(o_global_timebase_clock_start),
    .o_ext_sync_out_pin(o_ext_sync_out_pin)
);
`default_nettype wire

/* sim/pwm_partner_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pwm_partner_model
(
    input  wire logic       i_mclk,
    input  wire logic       i_reset,
    input  wire logic       i_fire,
    input  wire logic [6:0] i_clock_enable,
    input  wire logic [6:0] i_sync_in,
    output var  logic [6:0] o_sync_out
);
    // chained sync echo
    // A gated instance is frozen, so it neither starts nor passes a sync pulse.
    always @(posedge i_mclk)
        if (i_reset)
            o_sync_out <= 7'h00;
        else
            o_sync_out <= {i_sync_in[6:1], i_fire} & i_clock_enable;
endmodule // pwm_partner_model
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pwm_glue_map.vh"
module tb;
    localparam logic [11:0] CA = `OFS_CLOCK_ENABLE_CTRL_A;
    localparam logic [11:0] CB = `OFS_CLOCK_ENABLE_CTRL_B;
    localparam logic [11:0] CF = `OFS_SYNC_CONFIG;
    logic        clk, rst, psel, pen, pwr, sysn, pin, loop, fire, pready, perr, er, tbs, xout;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [6:0]  en, sin, sout;
    int          error_cnt = 0, samples_checked = 0, c0 = 0, c6 = 0, cx = 0;
    pwm_clock_gate_sync_glue i_dut
    (
        .i_mclk(clk), .i_reset(rst), .i_clk_en(1'b1), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hF), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(perr), .i_system_reset_n(sysn), .i_ext_sync_pin(pin),
        .i_timer_coprocessor_loop_sync(loop), .i_pwm_sync_out(sout),
        .o_pwm_instance_clock_enable(en), .o_pwm_sync_in(sin),
        .o_global_timebase_clock_start(tbs), .o_ext_sync_out_pin(xout)
    );
    pwm_partner_model i_far(.i_mclk(clk), .i_reset(rst), .i_fire(fire), .i_clock_enable(en),
                            .i_sync_in(sin), .o_sync_out(sout));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Counters only grow, so tests take differences and never race on clearing them.
    always @(posedge clk)
    begin
        c0 <= c0 + (sin[0] === 1'b1);
        c6 <= c6 + (sin[6] === 1'b1);
        cx <= cx + (xout === 1'b1);
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        // The slave answers after exactly one wait state.
        chk(n, 32'h2);
        rd = prdata;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task pulse(input int s);
        if (s == 0) fire <= 1'b1;
        else if (s == 1) pin <= 1'b1;
        else loop <= 1'b1;
        @(posedge clk);
        // The pin filter drops single-cycle pulses, so the pin is held for two cycles.
        if (s == 1) @(posedge clk);
        fire <= 1'b0;
        pin <= 1'b0;
        loop <= 1'b0;
        repeat (30) @(posedge clk);
    endtask
    task t_defaults;
        apb(1'b0, CA, 32'h0); chk(rd, 32'h0101_0100);
        apb(1'b0, CB, 32'h0); chk(rd, 32'h0101_0101);
        apb(1'b0, CF, 32'h0); chk(rd, 32'h0000_7F00);
        chk(en, 32'h7F);
        chk(tbs, 32'h0);
        $display("t_defaults done");
    endtask
    task t_gate_each;
        logic [11:0] a;
        logic [31:0] v;
        logic [6:0]  x;
        int          i;
        for (i = 0; i < 7; i++)
        begin
            a = (i < 3) ? CA : CB;
            v = (i < 3) ? 32'h0101_0100 : 32'h0101_0101;
            x = ~(7'h01 << i);
            apb(1'b1, a, v & ~(32'h1 << ((i < 3) ? 8 * i + 8 : 8 * (i - 3))));
            @(posedge clk);
            chk(en, x);
            apb(1'b1, a, v);
        end
        $display("t_gate_each done");
    endtask
    task t_sys_reset;
        apb(1'b1, CA, 32'h0);
        apb(1'b1, CB, 32'h0);
        @(posedge clk);
        chk(en, 32'h0);
        sysn <= 1'b0;
        repeat (8) @(posedge clk);
        chk(en, 32'h7F);
        sysn <= 1'b1;
        repeat (8) @(posedge clk);
        chk(en, 32'h0);
        apb(1'b1, CA, 32'h0101_0100);
        apb(1'b1, CB, 32'h0101_0101);
        $display("t_sys_reset done");
    endtask
    task t_refuse;
        apb(1'b0, 12'h010, 32'h0); chk(er, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, `OFS_GLUE_STATUS, 32'hFFFF_FFFF); chk(er, 32'h1);
        apb(1'b0, `OFS_GLUE_STATUS, 32'h0); chk(rd[6:0], 32'h7F);
        $display("t_refuse done");
    endtask
    task t_tb_start;
        apb(1'b1, CA, 32'h0101_0102);
        @(posedge clk);
        chk(tbs, 32'h1);
        apb(1'b1, CA, 32'h0101_0100);
        @(posedge clk);
        chk(tbs, 32'h0);
        $display("t_tb_start done");
    endtask
    task t_chain;
        int b6, bx;
        b6 = c6;
        bx = cx;
        pulse(0);
        chk(c6 - b6, 32'h1);
        chk(cx - bx, 32'h8);
        apb(1'b1, CF, 32'h0000_3F00);
        b6 = c6;
        pulse(0);
        chk(c6 - b6, 32'h0);
        apb(1'b1, CF, 32'h0000_7F00);
        $display("t_chain done");
    endtask
    task t_source;
        int b;
        b = c0; pulse(1); chk(c0 - b, 32'h2);
        b = c0; pulse(2); chk(c0 - b, 32'h0);
        apb(1'b1, CF, 32'h0000_7F01);
        b = c0; pulse(2); chk(c0 - b, 32'h1);
        b = c0; pulse(1); chk(c0 - b, 32'h0);
        apb(1'b1, CF, 32'h0000_7F00);
        $display("t_source done");
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        #500000;
        error_cnt++;
        print_verdict;
    end
    initial
    begin
        {rst, psel, pen, pwr, sysn, pin, loop, fire} = 8'h80;
        paddr = 12'h0;
        pwdata = 32'h0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
        sysn <= 1'b1;
        repeat (10) @(posedge clk);
        t_defaults;
        t_gate_each;
        t_sys_reset;
        t_refuse;
        t_tb_start;
        t_chain;
        t_source;
        print_verdict;
    end
endmodule // tb
`default_nettype wire
